// [hw/mrwd_bank.v]
// Metering control register five, result registers and stream channel control
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "mrwd_consts.vh"
module mrwd_bank #(
  parameter integer DC_UPD_CYC = `MRWD_DC_UPD_MS * `MRWD_MS_CYCLES, // DC refresh cycles
  parameter integer DC_STB_CYC = `MRWD_DC_STB_MS * `MRWD_MS_CYCLES, // DC settle cycles
  parameter integer RMS0_UPD_CYC = `MRWD_RMS0_UPD_MS * `MRWD_MS_CYCLES, // Instant RMS refresh
  parameter integer RMS0_STB_CYC = `MRWD_RMS0_STB_MS * `MRWD_MS_CYCLES, // Instant RMS settle
  parameter integer RMS1_UPD_CYC = `MRWD_RMS1_UPD_MS * `MRWD_MS_CYCLES, // Average RMS refresh
  parameter integer RMS1_STB_CYC = `MRWD_RMS1_STB_MS * `MRWD_MS_CYCLES  // Average RMS settle
) (
  input wire pclk, // Clock
  input wire presetn, // Power-on reset, async low
  input wire external_reset_pin_n, // Pin reset, low, asynchronous to pclk
  input wire rx_reset, // Reset via serial receive line, same clock
  input wire soft_reset, // Global software reset pulse, same clock
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [9:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  input wire [31:0] dc_u_in, // Computed DC voltage
  input wire [31:0] dc_ia_in, // Computed DC current A
  input wire [31:0] dc_ib_in, // Computed DC current B
  input wire [31:0] rms0_u_in, // Instant RMS voltage
  input wire [31:0] rms0_ia_in, // Instant RMS current A
  input wire [31:0] rms0_ib_in, // Instant RMS current B
  input wire [31:0] rms1_u_in, // Average RMS voltage
  input wire [31:0] rms1_ia_in, // Average RMS current A
  input wire [31:0] rms1_ib_in, // Average RMS current B
  input wire [31:0] avg_u_in, // Cycle-average RMS voltage
  input wire [31:0] avg_ia_in, // Cycle-average RMS current A
  input wire [31:0] avg_ib_in, // Cycle-average RMS current B
  input wire avg_done, // Cycle average window finished, pulse
  input wire [31:0] temp_in, // Die temperature
  input wire line_cycle, // One pulse per line cycle
  input wire trigger, // Waveform event trigger pulse
  output reg line_is_60hz_r, // Line frequency class; average spans 12 cycles when set
  output reg stream_on_r, // Stream channel active
  output reg stream_u_en_r, // Voltage samples streamed
  output reg stream_ia_en_r, // Current A samples streamed
  output reg stream_ib_en_r, // Current B samples streamed
  output reg stream_parity_select_r, // 0 odd, 1 even parity
  output reg stream_clock_polarity_r, // Clock polarity
  output reg stream_clock_phase_r // Clock phase
);
  ////////////////////////////////////////////////////////////////
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_RUN = 2'd1;
  localparam [1:0] ST_DONE = 2'd2;

  function [7:0] word_index;
    input [9:0] a;
    begin
      word_index = a[9:2];
    end
  endfunction

  reg pin_s1_r, pin_s2_r;
  reg [31:0] ctrl5_r;
  reg [31:0] res_r [0:12];
  reg [31:0] res_nxt [0:12];
  reg [1:0] st_r;
  reg [4:0] cyc_cnt_r;
  reg [3:0] avg_cnt_r;
  reg [3:0] avg_len_r;
  wire any_reset;
  wire tick_dc, tick_r0, tick_r1;
  wire stb_dc, stb_r0, stb_r1;
  wire [2:0] mode;
  wire [4:0] max_cyc;
  wire mstart, mstop, trig_start, manual_start, auto_stop, trig_stop;
  wire wr_acc, rd_acc;
  wire [7:0] idx;

  ////////////////////////////////////////////////////////////////
  // Pin reset synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      pin_s1_r <= external_reset_pin_n;
      pin_s2_r <= pin_s1_r;
    end
  end
  assign any_reset = !pin_s2_r || rx_reset || soft_reset;

  // Refresh timers, restarted by any synchronous reset source
  mrwd_refresh #(
    .UPD_CYC(DC_UPD_CYC),
    .STB_CYC(DC_STB_CYC)
  ) u_ref_dc (
    .pclk(pclk),
    .presetn(presetn),
    .clr(any_reset),
    .tick_r(tick_dc),
    .stable_r(stb_dc)
  );
  mrwd_refresh #(
    .UPD_CYC(RMS0_UPD_CYC),
    .STB_CYC(RMS0_STB_CYC)
  ) u_ref_r0 (
    .pclk(pclk),
    .presetn(presetn),
    .clr(any_reset),
    .tick_r(tick_r0),
    .stable_r(stb_r0)
  );
  mrwd_refresh #(
    .UPD_CYC(RMS1_UPD_CYC),
    .STB_CYC(RMS1_STB_CYC)
  ) u_ref_r1 (
    .pclk(pclk),
    .presetn(presetn),
    .clr(any_reset),
    .tick_r(tick_r1),
    .stable_r(stb_r1)
  );

  ////////////////////////////////////////////////////////////////
  // Result snapshots, whole words on one edge
  always @* begin
    res_nxt[0] = tick_r0 ? rms0_u_in : res_r[0];
    res_nxt[1] = tick_r0 ? rms0_ia_in : res_r[1];
    res_nxt[2] = tick_r0 ? rms0_ib_in : res_r[2];
    res_nxt[3] = tick_r1 ? rms1_u_in : res_r[3];
    res_nxt[4] = tick_r1 ? rms1_ia_in : res_r[4];
    res_nxt[5] = tick_r1 ? rms1_ib_in : res_r[5];
    res_nxt[6] = (avg_done && avg_cnt_r >= avg_len_r) ? avg_u_in : res_r[6];
    res_nxt[7] = (avg_done && avg_cnt_r >= avg_len_r) ? avg_ia_in : res_r[7];
    res_nxt[8] = (avg_done && avg_cnt_r >= avg_len_r) ? avg_ib_in : res_r[8];
    res_nxt[9] = tick_dc ? dc_u_in : res_r[9];
    res_nxt[10] = tick_dc ? dc_ia_in : res_r[10];
    res_nxt[11] = tick_dc ? dc_ib_in : res_r[11];
    res_nxt[12] = tick_r0 ? temp_in : res_r[12];
  end

  genvar gi;
  generate
    for (gi = 0; gi < 13; gi = gi + 1) begin : g_res
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          res_r[gi] <= 32'h00000000;
        else
          res_r[gi] <= res_nxt[gi];
      end
    end
  endgenerate

  // Line cycles counted per averaging window
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg_cnt_r <= 4'h0;
      avg_len_r <= 4'hA;
    end else begin
      avg_len_r <= line_is_60hz_r ? 4'hC : 4'hA;
      if (avg_done)
        avg_cnt_r <= 4'h0;
      else if (line_cycle && avg_cnt_r != 4'hF)
        avg_cnt_r <= avg_cnt_r + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  assign idx = word_index(paddr);
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl5_r <= `MRWD_CTRL5_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      line_is_60hz_r <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (any_reset)
        ctrl5_r <= `MRWD_CTRL5_RESET;
      else if (wr_acc && pready && idx == `MRWD_IDX_CTRL5)
        ctrl5_r <= pwdata & `MRWD_CTRL5_MASK;
      else if (st_r == ST_RUN && (mstart || mstop))
        ctrl5_r[`MRWD_BIT_MSTOP:`MRWD_BIT_MSTART] <= 2'b00;
      if (wr_acc && pready && idx == `MRWD_IDX_STAT)
        line_is_60hz_r <= pwdata[8];
      if (psel && !penable) begin
        pslverr <= 1'b0;
        case (idx)
          `MRWD_IDX_CTRL5: prdata <= ctrl5_r;
          `MRWD_IDX_RMS0U: prdata <= res_r[0];
          `MRWD_IDX_RMS0IA: prdata <= res_r[1];
          `MRWD_IDX_RMS0IB: prdata <= res_r[2];
          `MRWD_IDX_RMS1U: prdata <= res_r[3];
          `MRWD_IDX_RMS1IA: prdata <= res_r[4];
          `MRWD_IDX_RMS1IB: prdata <= res_r[5];
          `MRWD_IDX_AVGU: prdata <= res_r[6];
          `MRWD_IDX_AVGIA: prdata <= res_r[7];
          `MRWD_IDX_AVGIB: prdata <= res_r[8];
          `MRWD_IDX_DCU: prdata <= res_r[9];
          `MRWD_IDX_DCIA: prdata <= res_r[10];
          `MRWD_IDX_DCIB: prdata <= res_r[11];
          `MRWD_IDX_TEMP: prdata <= res_r[12];
          `MRWD_IDX_STAT: prdata <= {23'h000000, line_is_60hz_r, 3'h0, stb_dc, stb_r1, stb_r0, st_r};
          default: begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
        if (rd_acc == 1'b0 && pwrite && !(idx == `MRWD_IDX_CTRL5 || idx == `MRWD_IDX_STAT))
          pslverr <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Stream channel start and stop
  assign mode = ctrl5_r[`MRWD_MODE_LSB+2:`MRWD_MODE_LSB];
  assign max_cyc = {1'b0, ctrl5_r[`MRWD_LEN_LSB+3:`MRWD_LEN_LSB]} + 5'd1;
  assign mstart = ctrl5_r[`MRWD_BIT_MSTART];
  assign mstop = ctrl5_r[`MRWD_BIT_MSTOP];
  assign manual_start = (mode == 3'd0 || mode == 3'd1 || mode[2]) && mstart && !mstop;
  assign trig_start = (mode == 3'd2 || mode == 3'd3) && trigger && !mstop;
  assign auto_stop = (mode == 3'd0 || mode == 3'd3) && line_cycle && cyc_cnt_r + 5'd1 >= max_cyc;
  assign trig_stop = (mode == 3'd1) && trigger;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      cyc_cnt_r <= 5'd0;
    end else if (any_reset) begin
      st_r <= ST_IDLE;
      cyc_cnt_r <= 5'd0;
    end else begin
      case (st_r)
        ST_IDLE, ST_DONE: begin
          cyc_cnt_r <= 5'd0;
          if (manual_start || trig_start)
            st_r <= ST_RUN;
        end
        ST_RUN: begin
          if (mode[2] || mode == 3'd1 || mode == 3'd2) begin
            if (mstop || trig_stop)
              st_r <= ST_DONE;
          end else if (mstop || auto_stop)
            st_r <= ST_DONE;
          if (line_cycle)
            cyc_cnt_r <= cyc_cnt_r + 5'd1;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Registered stream outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stream_on_r <= 1'b0;
      stream_u_en_r <= 1'b0;
      stream_ia_en_r <= 1'b0;
      stream_ib_en_r <= 1'b0;
      stream_parity_select_r <= 1'b0;
      stream_clock_polarity_r <= 1'b0;
      stream_clock_phase_r <= 1'b0;
    end else begin
      stream_on_r <= (st_r == ST_RUN) && !mstop;
      stream_u_en_r <= ctrl5_r[`MRWD_BIT_USEL];
      stream_ia_en_r <= ctrl5_r[`MRWD_BIT_IASEL];
      stream_ib_en_r <= ctrl5_r[`MRWD_BIT_IBSEL] &&
        !(ctrl5_r[`MRWD_MEMEN_BIT] && ctrl5_r[`MRWD_BIT_USEL] && ctrl5_r[`MRWD_BIT_IASEL]);
      stream_parity_select_r <= ctrl5_r[`MRWD_BIT_PAR];
      stream_clock_polarity_r <= ctrl5_r[`MRWD_BIT_POL];
      stream_clock_phase_r <= ctrl5_r[`MRWD_BIT_PHA];
    end
  end
endmodule // mrwd_bank

// [common/mrwd_consts.vh]
// Register map, field positions and timing counts for the metering result bank
`ifndef MRWD_CONSTS_VH
`define MRWD_CONSTS_VH
`define MRWD_IDX_CTRL5 8'h07
`define MRWD_IDX_RMS0U 8'h0E
`define MRWD_IDX_RMS0IA 8'h0F
`define MRWD_IDX_RMS0IB 8'h10
`define MRWD_IDX_RMS1U 8'h19
`define MRWD_IDX_RMS1IA 8'h1A
`define MRWD_IDX_RMS1IB 8'h1B
`define MRWD_IDX_AVGU 8'h1E
`define MRWD_IDX_AVGIA 8'h1F
`define MRWD_IDX_AVGIB 8'h20
`define MRWD_IDX_DCU 8'h22
`define MRWD_IDX_DCIA 8'h23
`define MRWD_IDX_DCIB 8'h24
`define MRWD_IDX_TEMP 8'h68
`define MRWD_IDX_STAT 8'h70
`define MRWD_CTRL5_RESET 32'h00000000
`define MRWD_CTRL5_MASK 32'hFFFF77FF
`define MRWD_BIT_USEL 10
`define MRWD_BIT_IASEL 9
`define MRWD_BIT_IBSEL 8
`define MRWD_BIT_PAR 7
`define MRWD_BIT_POL 6
`define MRWD_BIT_PHA 5
`define MRWD_BIT_MSTOP 4
`define MRWD_BIT_MSTART 3
`define MRWD_MODE_LSB 0
`define MRWD_LEN_LSB 16
`define MRWD_MEMEN_BIT 28
`define MRWD_CLK_MHZ 100
`define MRWD_DC_UPD_MS 40
`define MRWD_DC_STB_MS 120
`define MRWD_RMS0_UPD_MS 10
`define MRWD_RMS0_STB_MS 30
`define MRWD_RMS1_UPD_MS 40
`define MRWD_RMS1_STB_MS 120
`define MRWD_MS_CYCLES (`MRWD_CLK_MHZ * 1000)
`endif

// [hw/mrwd_refresh.v]
// Refresh tick and settled flag for one group of result registers
`timescale 1ns/1ps
module mrwd_refresh #(
  parameter integer UPD_CYC = 1000000, // Cycles per refresh
  parameter integer STB_CYC = 3000000  // Cycles until settled
) (
  input wire pclk, // Clock
  input wire presetn, // Async reset, low
  input wire clr, // Synchronous restart
  output reg tick_r, // One-cycle refresh pulse
  output reg stable_r // Settled level
);
  reg [31:0] upd_cnt_r;
  reg [31:0] stb_cnt_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upd_cnt_r <= 32'h00000000;
      stb_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
      stable_r <= 1'b0;
    end else if (clr) begin
      upd_cnt_r <= 32'h00000000;
      stb_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
      stable_r <= 1'b0;
    end else begin
      tick_r <= (upd_cnt_r == UPD_CYC - 1);
      upd_cnt_r <= (upd_cnt_r == UPD_CYC - 1) ? 32'h00000000 : upd_cnt_r + 32'h00000001;
      if (stb_cnt_r == STB_CYC - 1)
        stable_r <= 1'b1;
      else
        stb_cnt_r <= stb_cnt_r + 32'h00000001;
    end
  end
endmodule // mrwd_refresh

// [dv/mrwd_bank_asserts.sv]
// Port-level checks on the metering result bank
`timescale 1ns/1ps
`include "mrwd_consts.vh"
module mrwd_bank_asserts (
  input wire pclk, // Clock
  input wire presetn, // Reset
  input wire external_reset_pin_n, // Pin reset
  input wire rx_reset, // Rx reset
  input wire soft_reset, // Soft reset
  input wire psel, // Select
  input wire penable, // Enable
  input wire pwrite, // Direction
  input wire [9:0] paddr, // Address
  input wire [31:0] pwdata, // Write data
  input wire [31:0] prdata, // Read data
  input wire pready, // Ready
  input wire pslverr, // Error
  input wire stream_on_r, // Channel on
  input wire stream_u_en_r, // U select
  input wire stream_ia_en_r, // IA select
  input wire stream_ib_en_r, // IB select
  input wire stream_parity_select_r, // Parity
  input wire stream_clock_polarity_r, // Polarity
  input wire stream_clock_phase_r // Phase
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [7:0] idx = paddr[9:2];
  wire ro_hit = idx inside {`MRWD_IDX_RMS0U, `MRWD_IDX_RMS0IA, `MRWD_IDX_RMS0IB, `MRWD_IDX_RMS1U,
    `MRWD_IDX_RMS1IA, `MRWD_IDX_RMS1IB, `MRWD_IDX_AVGU, `MRWD_IDX_AVGIA, `MRWD_IDX_AVGIB,
    `MRWD_IDX_DCU, `MRWD_IDX_DCIA, `MRWD_IDX_DCIB, `MRWD_IDX_TEMP};
  wire map_hit = ro_hit || idx == `MRWD_IDX_CTRL5 || idx == `MRWD_IDX_STAT;
  wire wr5 = pready && pwrite && !pslverr && idx == `MRWD_IDX_CTRL5;
  wire [5:0] cfg = {stream_u_en_r, stream_ia_en_r, stream_ib_en_r, stream_parity_select_r,
    stream_clock_polarity_r, stream_clock_phase_r};
  logic [31:0] wd_r;
  // IB select drops out when storage is on with all three selects set
  wire cfg_ok = cfg == {wd_r[10:9], wd_r[8] && !(wd_r[28] && &wd_r[10:8]), wd_r[7:5]};
  ////////////////////////////////////////
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_r <= 32'h00000000;
    end else if (wr5) begin
      wd_r <= pwdata;
    end
  end
  sequence s_wr5;
    wr5;
  endsequence
  a_access_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready missing or held too long");
  a_unmapped_err: assert property (pready && !map_hit |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  a_ro_write: assert property (pready && pwrite && ro_hit |-> pslverr)
    else $error("result register write not refused");
  a_cfg_follow: assert property (s_wr5 |=> ##[0:1] cfg_ok)
    else $error("stream settings do not follow control word");
  a_stop_holds: assert property (s_wr5 ##0 pwdata[4] |-> ##2 !stream_on_r [*2])
    else $error("channel on while stop set");
  a_start_on: assert property (s_wr5 ##0 (pwdata[4:3] == 2'b01 && (pwdata[2] || !pwdata[1]))
    |-> ##[1:4] stream_on_r)
    else $error("manual start ignored");
  a_sync_reset: assert property (soft_reset || rx_reset |-> ##[1:2] cfg == 6'h00 && !stream_on_r)
    else $error("sync reset left settings");
  a_pin_reset: assert property ($fell(external_reset_pin_n) |-> ##[3:5] cfg == 6'h00 && !stream_on_r)
    else $error("pin reset left settings");
  a_reset_idle: assert property ($rose(presetn) |-> !stream_on_r && !pready && cfg == 6'h00)
    else $error("outputs not idle after reset");
endmodule // mrwd_bank_asserts

// [dv/mrwd_src_model.sv]
// Source of result words, line cycle and average-ready pulses
`timescale 1ns/1ps
module mrwd_src_model #(
  parameter int LC_PER = 8, // Cycles per line cycle
  parameter int AVG_LC = 12 // Line cycles per average window, enough for either line class
) (
  input logic pclk, // Clock
  input logic presetn, // Reset
  output logic [31:0] val [13], // Result words
  output logic line_cycle, // Line cycle pulse
  output logic avg_done // Average ready pulse
);
  int cnt;
  int nlc;
  always_comb begin
    for (int k = 0; k < 13; k++) val[k] = 32'h5A000000 + k;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      nlc <= 0;
      line_cycle <= 1'b0;
      avg_done <= 1'b0;
    end else begin
      cnt <= (cnt == LC_PER - 1) ? 0 : cnt + 1;
      line_cycle <= (cnt == LC_PER - 1);
      // Average ready the cycle after the window's last line cycle
      if (line_cycle)
        nlc <= (nlc == AVG_LC - 1) ? 0 : nlc + 1;
      avg_done <= line_cycle && nlc == AVG_LC - 1;
    end
  end
endmodule // mrwd_src_model

// [dv/tb_metering_results_and_wave_dma_ctrl.sv]
// Self-checking bench for the metering result and stream control bank
`timescale 1ns/1ps
`include "mrwd_consts.vh"
module tb_metering_results_and_wave_dma_ctrl;
  logic pclk, presetn, pin_n, rx_reset, soft_reset, trigger, psel, penable, pwrite, err;
  logic [9:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, line_cycle, avg_done, on, u_en, ia_en, ib_en, par, pol, pha, hz60;
  wire [31:0] val [13];
  int failures, num_checks, cnt, n;
  logic [7:0] ridx [13] = '{`MRWD_IDX_DCU, `MRWD_IDX_DCIA, `MRWD_IDX_DCIB, `MRWD_IDX_RMS0U,
    `MRWD_IDX_RMS0IA, `MRWD_IDX_RMS0IB, `MRWD_IDX_RMS1U, `MRWD_IDX_RMS1IA, `MRWD_IDX_RMS1IB,
    `MRWD_IDX_AVGU, `MRWD_IDX_AVGIA, `MRWD_IDX_AVGIB, `MRWD_IDX_TEMP};
  logic [31:0] cw [8] = '{32'h00000400, 32'h00000200, 32'h00000100, 32'h00000080, 32'h00000040,
    32'h00000020, 32'h10000700, 32'h00000700};
  logic [5:0] co [8] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h30, 6'h38};
  localparam int UPD_CYC = 20; // Shortened refresh period
  localparam int STB_CYC = 3 * UPD_CYC; // Settled after three refreshes
  logic lc_d = 1'b0;
  mrwd_bank #(.DC_UPD_CYC(UPD_CYC), .DC_STB_CYC(STB_CYC), .RMS0_UPD_CYC(UPD_CYC), .RMS0_STB_CYC(STB_CYC),
    .RMS1_UPD_CYC(UPD_CYC), .RMS1_STB_CYC(STB_CYC)) dut (
    .pclk(pclk), .presetn(presetn), .external_reset_pin_n(pin_n), .rx_reset(rx_reset),
    .soft_reset(soft_reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dc_u_in(val[0]), .dc_ia_in(val[1]), .dc_ib_in(val[2]), .rms0_u_in(val[3]), .rms0_ia_in(val[4]),
    .rms0_ib_in(val[5]), .rms1_u_in(val[6]), .rms1_ia_in(val[7]), .rms1_ib_in(val[8]),
    .avg_u_in(val[9]), .avg_ia_in(val[10]), .avg_ib_in(val[11]), .avg_done(avg_done),
    .temp_in(val[12]), .line_cycle(line_cycle), .trigger(trigger), .line_is_60hz_r(hz60),
    .stream_on_r(on), .stream_u_en_r(u_en), .stream_ia_en_r(ia_en), .stream_ib_en_r(ib_en),
    .stream_parity_select_r(par), .stream_clock_polarity_r(pol), .stream_clock_phase_r(pha));
  mrwd_src_model src (.pclk(pclk), .presetn(presetn), .val(val), .line_cycle(line_cycle), .avg_done(avg_done));
  always @(posedge pclk) lc_d <= line_cycle;
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) chk("apb timeout", 0, 1);
    if (n == 50) print_verdict();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts line cycles while running; delayed one edge to match the registered on flag
  task automatic wait_on(input logic v);
    for (n = 0; on !== v && n < 300; n++) begin
      @(posedge pclk);
      if (lc_d === 1'b1 && on === 1'b1) cnt++;
    end
    chk("stream on", v, on);
    if (n == 300) print_verdict();
  endtask
  task automatic trig();
    @(posedge pclk);
    trigger <= 1'b1;
    @(posedge pclk);
    trigger <= 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, rx_reset, soft_reset, trigger} = 7'h00;
    pin_n = 1'b1;
    paddr = 10'h000;
    pwdata = 32'h00000000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `MRWD_IDX_CTRL5, 0);
    chk("ctrl5 default", `MRWD_CTRL5_RESET, rd);
    for (int r = 0; r < 8; r++) begin
      apb(1, `MRWD_IDX_CTRL5, cw[r]);
      repeat (3) @(posedge pclk);
      chk("stream selects", {26'h0, co[r]}, {26'h0, u_en, ia_en, ib_en, par, pol, pha});
      apb(0, `MRWD_IDX_CTRL5, 0);
      chk("ctrl5 readback", cw[r] & `MRWD_CTRL5_MASK, rd);
    end
    repeat (60) @(posedge pclk);
    for (int k = 0; k < 13; k++) begin
      apb(1, ridx[k], 32'hFFFFFFFF);
      chk("ro write error", 1, err);
      apb(0, ridx[k], 0);
      chk("result word", 32'h5A000000 + k, rd);
    end
    apb(0, `MRWD_IDX_STAT, 0);
    chk("settled flags", 7, rd[4:2]);
    apb(1, `MRWD_IDX_STAT, 32'h00000100);
    @(posedge pclk);
    chk("line class", 1, hz60);
    apb(0, 8'h01, 0);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, rd);
    for (int m = 4; m < 8; m++) begin
      apb(1, `MRWD_IDX_CTRL5, 32'h8 | m);
      wait_on(1);
      apb(1, `MRWD_IDX_CTRL5, 32'h10 | m);
      wait_on(0);
    end
    apb(1, `MRWD_IDX_CTRL5, 32'h0000001C);
    repeat (6) @(posedge pclk);
    chk("start with stop", 0, on);
    apb(1, `MRWD_IDX_CTRL5, 32'h00000002);
    repeat (6) @(posedge pclk);
    chk("idle before trigger", 0, on);
    trig();
    wait_on(1);
    apb(1, `MRWD_IDX_CTRL5, 32'h00000012);
    wait_on(0);
    apb(1, `MRWD_IDX_CTRL5, 32'h00000003);
    trig();
    wait_on(1);
    wait_on(0);
    apb(1, `MRWD_IDX_CTRL5, 32'h00000009);
    wait_on(1);
    trig();
    wait_on(0);
    cnt = 0;
    apb(1, `MRWD_IDX_CTRL5, 32'h00010008);
    wait_on(1);
    wait_on(0);
    chk("auto stop cycles", 2, cnt);
    for (int s = 0; s < 3; s++) begin
      apb(1, `MRWD_IDX_CTRL5, 32'h000007E0);
      repeat (3) @(posedge pclk);
      soft_reset <= (s == 0);
      rx_reset <= (s == 1);
      pin_n <= (s != 2);
      repeat (4) @(posedge pclk);
      {soft_reset, rx_reset, pin_n} <= 3'b001;
      apb(0, `MRWD_IDX_CTRL5, 0);
      chk("ctrl5 after reset", 0, rd);
    end
    print_verdict();
  end
endmodule // tb_metering_results_and_wave_dma_ctrl
bind mrwd_bank mrwd_bank_asserts u_chk (.pclk(pclk), .presetn(presetn), .external_reset_pin_n(external_reset_pin_n),
  .rx_reset(rx_reset), .soft_reset(soft_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stream_on_r(stream_on_r), .stream_u_en_r(stream_u_en_r), .stream_ia_en_r(stream_ia_en_r),
  .stream_ib_en_r(stream_ib_en_r), .stream_parity_select_r(stream_parity_select_r),
  .stream_clock_polarity_r(stream_clock_polarity_r), .stream_clock_phase_r(stream_clock_phase_r));
